// file: rtl/rcs_regs.sv
// Radio CRC, spacing, phase and address-base registers with their logic.
//
// Overview of operation
// - CRC register loads the programmed seed at the start of every frame.
// - Programmable gap in microseconds separates consecutive frames.
// - Signal strength reads as unsigned magnitude; true level is its negative in dBm.
// - Phase field reads 0 while the transceiver is disabled.
// - Receive phases read 1 rampup, 2 waiting, 3 receiving, 4 shutdown.
// - Transmit phases read 9 rampup, 10 waiting, 11 sending, 12 shutdown.
// - Whitening generator is seeded from a software-written register.
// - 32-bit writable compare value is matched against the on-air bit count.
// - Eight 32-bit address base segments sit at base plus four times n.
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps
module rcs_regs #(
  parameter int CRC_W = 24
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Avalon-MM slave
  input  wire logic [11:0] avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Transceiver control events
  input  wire logic        rx_enable_i,
  input  wire logic        tx_enable_i,
  input  wire logic        rampup_done_i,
  input  wire logic        start_i,
  input  wire logic        frame_end_i,
  input  wire logic        disable_i,
  input  wire logic        shutdown_done_i,
  // On-air bit stream
  input  wire logic        bit_tick_i,
  input  wire logic        bit_i,
  // Signal strength measurement
  input  wire logic        rssi_valid_i,
  input  wire logic [6:0]  rssi_i,
  // Results to the radio core
  output logic [3:0]       phase_o,
  output logic [CRC_W-1:0] crc_o,
  output logic             whiten_bit_o,
  output logic             bit_match_o,
  output logic             gap_done_o,
  output logic [255:0]     dev_addr_base_o
);

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------

  // Software-visible code of each phase.
  function automatic logic [3:0] phase_code(input rcs_pkg::rcs_phase_t s);
    case (s)
      rcs_pkg::ST_DISABLED:    phase_code = rcs_pkg::PH_DISABLED;
      rcs_pkg::ST_RX_RAMPUP:   phase_code = rcs_pkg::PH_RX_RAMPUP;
      rcs_pkg::ST_RX_WAITING:  phase_code = rcs_pkg::PH_RX_WAITING;
      rcs_pkg::ST_RX_ACTIVE:   phase_code = rcs_pkg::PH_RX_ACTIVE;
      rcs_pkg::ST_RX_SHUTDOWN: phase_code = rcs_pkg::PH_RX_SHUTDOWN;
      rcs_pkg::ST_TX_RAMPUP:   phase_code = rcs_pkg::PH_TX_RAMPUP;
      rcs_pkg::ST_TX_WAITING:  phase_code = rcs_pkg::PH_TX_WAITING;
      rcs_pkg::ST_TX_ACTIVE:   phase_code = rcs_pkg::PH_TX_ACTIVE;
      rcs_pkg::ST_TX_SHUTDOWN: phase_code = rcs_pkg::PH_TX_SHUTDOWN;
      default:                 phase_code = rcs_pkg::PH_DISABLED;
    endcase
  endfunction

  // Merge write data into a word under the byte enables.
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    merge = r;
  endfunction

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  rcs_pkg::rcs_phase_t st_q;
  rcs_pkg::rcs_phase_t st_d;
  logic [31:0] poly_q,   poly_d;
  logic [31:0] seed_q,   seed_d;
  logic [31:0] gap_q,    gap_d;
  logic [31:0] wseed_q,  wseed_d;
  logic [31:0] match_q,  match_d;
  logic [31:0] seg_q [rcs_pkg::SEG_COUNT];
  logic [31:0] seg_d [rcs_pkg::SEG_COUNT];
  logic [6:0]  rssi_q,   rssi_d;
  logic [31:0] rdata_q,  rdata_d;
  logic        wait_q,   wait_d;
  logic [6:0]  lfsr_q,   lfsr_d;
  logic [31:0] bcnt_q,   bcnt_d;
  logic        bmatch_q, bmatch_d;
  logic [3:0]  phase_q;
  logic        req;
  logic        commit;
  logic        in_wait;
  logic        in_active;
  logic        start_now;
  logic        shift_now;
  logic        gap_done;
  logic [11:0] seg_rel;
  logic        seg_hit;
  logic [2:0]  seg_idx;

  // ---------------------------------------------------------------
  // Bus handshake
  // ---------------------------------------------------------------

  // Each access stalls one cycle, then completes with waitrequest low.
  // The extra cycle lets read data come from a flop at no mux-depth cost.
  assign req    = avs_read_i | avs_write_i;
  assign commit = req & ~wait_q;

  always_comb begin
    wait_d = 1'b1;
    if (req && wait_q) begin
      wait_d = 1'b0;
    end
  end

  // Address-base window decode; anything else unmapped reads zero.
  assign seg_rel = avs_address_i - rcs_pkg::OFS_SEG_BASE;
  assign seg_hit = (avs_address_i >= rcs_pkg::OFS_SEG_BASE) &&
                   (seg_rel < 12'(rcs_pkg::SEG_COUNT * 4)) &&
                   (avs_address_i[1:0] == 2'b00);
  assign seg_idx = seg_rel[4:2];

  // Read data is captured in the stall cycle and held for the answer.
  always_comb begin
    rdata_d = rdata_q;
    if (avs_read_i && wait_q) begin
      rdata_d = rcs_pkg::RST_WORD;
      case (avs_address_i)
        rcs_pkg::OFS_CRC_POLY:    rdata_d = poly_q;
        rcs_pkg::OFS_CRC_SEED:    rdata_d = seed_q;
        rcs_pkg::OFS_IFS_GAP:     rdata_d = gap_q;
        rcs_pkg::OFS_RSSI:        rdata_d = {25'h0, rssi_q};
        rcs_pkg::OFS_PHASE:       rdata_d = {28'h0, phase_q};
        rcs_pkg::OFS_WHITEN_SEED: rdata_d = wseed_q;
        rcs_pkg::OFS_BIT_MATCH:   rdata_d = match_q;
        default: begin
          if (seg_hit) begin
            rdata_d = seg_q[seg_idx];
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Writable registers
  // ---------------------------------------------------------------

  // Writes land on the completing edge only; read-only offsets ignore them.
  always_comb begin
    poly_d  = poly_q;
    seed_d  = seed_q;
    gap_d   = gap_q;
    wseed_d = wseed_q;
    match_d = match_q;
    for (int i = 0; i < rcs_pkg::SEG_COUNT; i++) begin
      seg_d[i] = seg_q[i];
    end
    if (commit && avs_write_i) begin
      case (avs_address_i)
        rcs_pkg::OFS_CRC_POLY:    poly_d  = merge(poly_q, avs_writedata_i, avs_byteenable_i);
        rcs_pkg::OFS_CRC_SEED:    seed_d  = merge(seed_q, avs_writedata_i, avs_byteenable_i);
        rcs_pkg::OFS_IFS_GAP:     gap_d   = merge(gap_q, avs_writedata_i, avs_byteenable_i);
        rcs_pkg::OFS_WHITEN_SEED: wseed_d = merge(wseed_q, avs_writedata_i, avs_byteenable_i);
        rcs_pkg::OFS_BIT_MATCH:   match_d = merge(match_q, avs_writedata_i, avs_byteenable_i);
        default: begin
          if (seg_hit) begin
            seg_d[seg_idx] = merge(seg_q[seg_idx], avs_writedata_i, avs_byteenable_i);
          end
        end
      endcase
    end
  end

  // Magnitude is kept unsigned; the core reports level without its sign.
  always_comb begin
    rssi_d = rssi_q;
    if (rssi_valid_i) begin
      rssi_d = rssi_i;
    end
  end

  // ---------------------------------------------------------------
  // Transceiver phase sequencer
  // ---------------------------------------------------------------

  assign in_wait   = (st_q == rcs_pkg::ST_RX_WAITING) || (st_q == rcs_pkg::ST_TX_WAITING);
  assign in_active = (st_q == rcs_pkg::ST_RX_ACTIVE) || (st_q == rcs_pkg::ST_TX_ACTIVE);
  // A frame opens on an explicit start or when the gap after the last expires.
  assign start_now = in_wait && !disable_i && (start_i || gap_done);
  assign shift_now = in_active && bit_tick_i;

  // Disable wins over a start arriving in the same cycle.
  always_comb begin
    st_d = st_q;
    case (st_q)
      rcs_pkg::ST_DISABLED: begin
        if (rx_enable_i) begin
          st_d = rcs_pkg::ST_RX_RAMPUP;
        end else if (tx_enable_i) begin
          st_d = rcs_pkg::ST_TX_RAMPUP;
        end
      end
      rcs_pkg::ST_RX_RAMPUP: begin
        if (disable_i) st_d = rcs_pkg::ST_RX_SHUTDOWN;
        else if (rampup_done_i) st_d = rcs_pkg::ST_RX_WAITING;
      end
      rcs_pkg::ST_RX_WAITING: begin
        if (disable_i) st_d = rcs_pkg::ST_RX_SHUTDOWN;
        else if (start_now) st_d = rcs_pkg::ST_RX_ACTIVE;
      end
      rcs_pkg::ST_RX_ACTIVE: begin
        if (disable_i) st_d = rcs_pkg::ST_RX_SHUTDOWN;
        else if (frame_end_i) st_d = rcs_pkg::ST_RX_WAITING;
      end
      rcs_pkg::ST_RX_SHUTDOWN: begin
        if (shutdown_done_i) st_d = rcs_pkg::ST_DISABLED;
      end
      rcs_pkg::ST_TX_RAMPUP: begin
        if (disable_i) st_d = rcs_pkg::ST_TX_SHUTDOWN;
        else if (rampup_done_i) st_d = rcs_pkg::ST_TX_WAITING;
      end
      rcs_pkg::ST_TX_WAITING: begin
        if (disable_i) st_d = rcs_pkg::ST_TX_SHUTDOWN;
        else if (start_now) st_d = rcs_pkg::ST_TX_ACTIVE;
      end
      rcs_pkg::ST_TX_ACTIVE: begin
        if (disable_i) st_d = rcs_pkg::ST_TX_SHUTDOWN;
        else if (frame_end_i) st_d = rcs_pkg::ST_TX_WAITING;
      end
      rcs_pkg::ST_TX_SHUTDOWN: begin
        if (shutdown_done_i) st_d = rcs_pkg::ST_DISABLED;
      end
      default: st_d = rcs_pkg::ST_DISABLED;
    endcase
  end

  // ---------------------------------------------------------------
  // Whitening generator and bit counter
  // ---------------------------------------------------------------

  // Seven-stage generator, reseeded at every frame start.
  always_comb begin
    lfsr_d = lfsr_q;
    if (start_now) begin
      lfsr_d = wseed_q[6:0];
    end else if (shift_now) begin
      lfsr_d = {lfsr_q[5:0], 1'b0} ^ (lfsr_q[6] ? rcs_pkg::WHITEN_TAPS : 7'h00);
    end
  end

  // Count on-air bits; flag the bit on which the count equals the compare.
  always_comb begin
    bcnt_d   = bcnt_q;
    bmatch_d = 1'b0;
    if (start_now) begin
      bcnt_d = 32'h0000_0000;
    end else if (shift_now) begin
      bcnt_d   = bcnt_q + 32'h0000_0001;
      bmatch_d = (bcnt_d == match_q);
    end
  end

  // ---------------------------------------------------------------
  // Submodules
  // ---------------------------------------------------------------

  rcs_crc_unit #(
    .CRC_W (CRC_W)
  ) u_crc (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .load_i  (start_now),
    .seed_i  (seed_q[CRC_W-1:0]),
    .poly_i  (poly_q[CRC_W-1:0]),
    .shift_i (shift_now),
    .bit_i   (bit_i),
    .crc_o   (crc_o)
  );

  rcs_gap_timer u_gap (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_i),
    .start_i  (in_active && frame_end_i && !disable_i),
    .gap_us_i (gap_q),
    .done_o   (gap_done)
  );

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------

  // All state registers; phase code is registered so it matches the state.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q     <= rcs_pkg::ST_DISABLED;
      phase_q  <= rcs_pkg::PH_DISABLED;
      poly_q   <= rcs_pkg::RST_WORD;
      seed_q   <= rcs_pkg::RST_WORD;
      gap_q    <= rcs_pkg::RST_WORD;
      wseed_q  <= rcs_pkg::RST_WORD;
      match_q  <= rcs_pkg::RST_WORD;
      for (int i = 0; i < rcs_pkg::SEG_COUNT; i++) begin
        seg_q[i] <= rcs_pkg::RST_WORD;
      end
      rssi_q   <= '0;
      rdata_q  <= rcs_pkg::RST_WORD;
      wait_q   <= 1'b1;
      lfsr_q   <= '0;
      bcnt_q   <= '0;
      bmatch_q <= 1'b0;
    end else begin
      st_q     <= st_d;
      phase_q  <= phase_code(st_d);
      poly_q   <= poly_d;
      seed_q   <= seed_d;
      gap_q    <= gap_d;
      wseed_q  <= wseed_d;
      match_q  <= match_d;
      for (int i = 0; i < rcs_pkg::SEG_COUNT; i++) begin
        seg_q[i] <= seg_d[i];
      end
      rssi_q   <= rssi_d;
      rdata_q  <= rdata_d;
      wait_q   <= wait_d;
      lfsr_q   <= lfsr_d;
      bcnt_q   <= bcnt_d;
      bmatch_q <= bmatch_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign avs_readdata_o    = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign phase_o           = phase_q;
  assign whiten_bit_o      = lfsr_q[6];
  assign bit_match_o       = bmatch_q;
  assign gap_done_o        = gap_done;

  for (genvar g = 0; g < rcs_pkg::SEG_COUNT; g++) begin : g_seg
    assign dev_addr_base_o[g*32 +: 32] = seg_q[g];
  end

endmodule

// file: rtl/rcs_pkg.sv
// Shared constants for the radio CRC and state register slice.
package rcs_pkg;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_CRC_POLY    = 12'h538;
  localparam logic [11:0] OFS_CRC_SEED    = 12'h53c;
  localparam logic [11:0] OFS_IFS_GAP     = 12'h544;
  localparam logic [11:0] OFS_RSSI        = 12'h548;
  localparam logic [11:0] OFS_PHASE       = 12'h550;
  localparam logic [11:0] OFS_WHITEN_SEED = 12'h554;
  localparam logic [11:0] OFS_BIT_MATCH   = 12'h560;
  localparam logic [11:0] OFS_SEG_BASE    = 12'h600;
  localparam logic [11:0] SEG_STRIDE      = 12'h004;
  localparam int          SEG_COUNT       = 8;

  // ---------------------------------------------------------------
  // Reset values and field layout
  // ---------------------------------------------------------------
  localparam logic [31:0] RST_WORD        = 32'h0000_0000;
  localparam int          RSSI_W          = 7;
  localparam int          PHASE_W         = 4;
  localparam int          WHITEN_W        = 7;
  localparam logic [6:0]  WHITEN_TAPS     = 7'h11;

  // ---------------------------------------------------------------
  // Transceiver phase codes
  // ---------------------------------------------------------------
  localparam logic [3:0] PH_DISABLED    = 4'h0;
  localparam logic [3:0] PH_RX_RAMPUP   = 4'h1;
  localparam logic [3:0] PH_RX_WAITING  = 4'h2;
  localparam logic [3:0] PH_RX_ACTIVE   = 4'h3;
  localparam logic [3:0] PH_RX_SHUTDOWN = 4'h4;
  localparam logic [3:0] PH_TX_RAMPUP   = 4'h9;
  localparam logic [3:0] PH_TX_WAITING  = 4'ha;
  localparam logic [3:0] PH_TX_ACTIVE   = 4'hb;
  localparam logic [3:0] PH_TX_SHUTDOWN = 4'hc;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int US_NS         = 1000;
  localparam int CYC_PER_US    = US_NS / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    ST_DISABLED, ST_RX_RAMPUP, ST_RX_WAITING, ST_RX_ACTIVE, ST_RX_SHUTDOWN,
    ST_TX_RAMPUP, ST_TX_WAITING, ST_TX_ACTIVE, ST_TX_SHUTDOWN
  } rcs_phase_t;

endpackage

// file: rtl/rcs_crc_unit.sv
// Serial CRC shift register with programmable taps and seed.
`timescale 1ns/1ps
module rcs_crc_unit #(
  parameter int CRC_W = 24
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // Control
  input  wire logic             load_i,
  input  wire logic [CRC_W-1:0] seed_i,
  input  wire logic [CRC_W-1:0] poly_i,
  input  wire logic             shift_i,
  input  wire logic             bit_i,
  // Result
  output logic      [CRC_W-1:0] crc_o
);

  logic [CRC_W-1:0] crc_q;
  logic [CRC_W-1:0] crc_d;
  logic [CRC_W-1:0] taps;
  logic             fb;

  // Constant term is always present, so software bit 0 has no effect.
  assign taps = {poly_i[CRC_W-1:1], 1'b1};
  assign fb   = bit_i ^ crc_q[CRC_W-1];

  // Next value: seed at computation start, otherwise one shift per bit.
  always_comb begin
    crc_d = crc_q;
    if (load_i) begin
      crc_d = seed_i;
    end else if (shift_i) begin
      crc_d = {crc_q[CRC_W-2:0], 1'b0} ^ (fb ? taps : '0);
    end
  end

  // State register.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      crc_q <= '0;
    end else begin
      crc_q <= crc_d;
    end
  end

  assign crc_o = crc_q;

endmodule

// file: rtl/rcs_gap_timer.sv
// Inter-frame gap timer counting whole microseconds.
`timescale 1ns/1ps
module rcs_gap_timer (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Control
  input  wire logic        start_i,
  input  wire logic [31:0] gap_us_i,
  // Result
  output logic             done_o
);

  logic [31:0] us_q;
  logic [31:0] us_d;
  logic [7:0]  cyc_q;
  logic [7:0]  cyc_d;
  logic        run_q;
  logic        run_d;
  logic        done_q;
  logic        done_d;

  // A zero gap expires on the next cycle; a restart cancels a pending gap.
  always_comb begin
    us_d   = us_q;
    cyc_d  = cyc_q;
    run_d  = run_q;
    done_d = 1'b0;
    if (start_i) begin
      us_d  = gap_us_i;
      cyc_d = 8'(rcs_pkg::CYC_PER_US - 1);
      run_d = 1'b1;
      if (gap_us_i == 32'h0000_0000) begin
        run_d  = 1'b0;
        done_d = 1'b1;
      end
    end else if (run_q) begin
      if (cyc_q != 8'h00) begin
        cyc_d = cyc_q - 8'h01;
      end else begin
        cyc_d = 8'(rcs_pkg::CYC_PER_US - 1);
        us_d  = us_q - 32'h0000_0001;
        if (us_q == 32'h0000_0001) begin
          run_d  = 1'b0;
          done_d = 1'b1;
        end
      end
    end
  end

  // State registers.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      us_q   <= '0;
      cyc_q  <= '0;
      run_q  <= 1'b0;
      done_q <= 1'b0;
    end else begin
      us_q   <= us_d;
      cyc_q  <= cyc_d;
      run_q  <= run_d;
      done_q <= done_d;
    end
  end

  assign done_o = done_q;

endmodule

// file: test/rcs_regs_monitor.sv
// Checker for the bus handshake, phase sequencing and result pulses.
`timescale 1ns/1ps
module rcs_regs_monitor (
  // Clock and reset
  input wire logic         clk_i,
  input wire logic         rst_n_i,
  // Register bus
  input wire logic         avs_read_i,
  input wire logic         avs_write_i,
  input wire logic         avs_waitrequest_o,
  // Core events
  input wire logic         rx_enable_i,
  input wire logic         tx_enable_i,
  input wire logic         start_i,
  input wire logic         disable_i,
  input wire logic         shutdown_done_i,
  input wire logic         bit_tick_i,
  // Results
  input wire logic [3:0]   phase_o,
  input wire logic         bit_match_o,
  input wire logic         gap_done_o,
  input wire logic [255:0] dev_addr_base_o
);
  // ---------------------------------------------------------------
  // Clocking and access steps
  // ---------------------------------------------------------------
  // All checks share the single clock; reset disables them.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_stall;
    (avs_read_i || avs_write_i) && avs_waitrequest_o && $past(avs_waitrequest_o);
  endsequence
  sequence s_ack;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  bus_ack_a: assert property (s_stall |=> s_ack)
    else $error("bus access not answered after one stall cycle");
  phase_code_a: assert property (phase_o inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h9, 4'ha, 4'hb, 4'hc})
    else $error("phase code outside the legal set");
  rx_enter_a: assert property (phase_o == rcs_pkg::PH_DISABLED && rx_enable_i |=> phase_o == rcs_pkg::PH_RX_RAMPUP)
    else $error("receive enable did not reach rampup");
  tx_enter_a: assert property (phase_o == rcs_pkg::PH_DISABLED && tx_enable_i && !rx_enable_i
                               |=> phase_o == rcs_pkg::PH_TX_RAMPUP)
    else $error("transmit enable did not reach rampup");
  rx_frame_a: assert property (phase_o == rcs_pkg::PH_RX_WAITING && start_i && !disable_i
                               |=> phase_o == rcs_pkg::PH_RX_ACTIVE)
    else $error("receive start did not reach active");
  tx_frame_a: assert property (phase_o == rcs_pkg::PH_TX_WAITING && start_i && !disable_i
                               |=> phase_o == rcs_pkg::PH_TX_ACTIVE)
    else $error("transmit start did not reach active");
  off_return_a: assert property ((phase_o == rcs_pkg::PH_RX_SHUTDOWN || phase_o == rcs_pkg::PH_TX_SHUTDOWN)
                                 && shutdown_done_i |=> phase_o == 4'h0)
    else $error("shutdown done did not return to disabled");
  match_cause_a: assert property ($rose(bit_match_o) |-> $past(bit_tick_i) || $past(bit_tick_i, 2))
    else $error("bit match without a preceding bit tick");
  gap_pulse_a: assert property (gap_done_o |=> !gap_done_o)
    else $error("gap done longer than one cycle");
  base_hold_a: assert property (!$past(avs_write_i && !avs_waitrequest_o) |-> $stable(dev_addr_base_o))
    else $error("address base changed without a write");
endmodule

bind rcs_regs rcs_regs_monitor rcs_regs_monitor_inst (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_waitrequest_o(avs_waitrequest_o), .rx_enable_i(rx_enable_i), .tx_enable_i(tx_enable_i),
  .start_i(start_i), .disable_i(disable_i), .shutdown_done_i(shutdown_done_i), .bit_tick_i(bit_tick_i),
  .phase_o(phase_o), .bit_match_o(bit_match_o), .gap_done_o(gap_done_o), .dev_addr_base_o(dev_addr_base_o)
);

// file: test/rcs_regs_tb_top.sv
// Self-checking bench for the radio CRC, phase and address-base registers.
`timescale 1ns/1ps
module rcs_regs_tb_top;
  // ---------------------------------------------------------------
  // Stimulus, results and counters
  // ---------------------------------------------------------------
  logic          clk_i   = 1'b0;
  logic          rst_n_i = 1'b0;
  logic [11:0]   adr     = 12'h000;
  logic          rd      = 1'b0;
  logic          wr      = 1'b0;
  logic [31:0]   wd      = 32'h0000_0000;
  logic [3:0]    be      = 4'h0;
  logic [6:0]    ev      = 7'h00;
  logic          tick    = 1'b0;
  logic          dbit    = 1'b0;
  logic          rv      = 1'b0;
  logic [6:0]    rssi    = 7'h00;
  logic [31:0]   rdata;
  logic          wait_r;
  logic [3:0]    phase;
  logic [23:0]   crc;
  logic          wbit;
  logic          match;
  logic          gap_done;
  logic [255:0]  seg;
  int            fail_count = 0;
  int            tests_run  = 0;
  int            cyc        = 0;

  rcs_regs rcs_regs_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_r),
    .rx_enable_i(ev[0]), .tx_enable_i(ev[1]), .rampup_done_i(ev[2]), .start_i(ev[3]), .frame_end_i(ev[4]),
    .disable_i(ev[5]), .shutdown_done_i(ev[6]), .bit_tick_i(tick), .bit_i(dbit), .rssi_valid_i(rv),
    .rssi_i(rssi), .phase_o(phase), .crc_o(crc), .whiten_bit_o(wbit), .bit_match_o(match),
    .gap_done_o(gap_done), .dev_addr_base_o(seg)
  );

  // ---------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ---------------------------------------------------------------
  // The ceiling leaves ample margin over the few hundred cycles needed.
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (fail_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic cmp32(input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // One access; the request is held until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] b,
                     output logic [31:0] q);
    @(posedge clk_i);
    adr <= a;
    wd  <= d;
    be  <= b;
    rd  <= !w;
    wr  <= w;
    do @(posedge clk_i); while (wait_r !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wreg(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hf, q);
  endtask

  task automatic rreg(input logic [11:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0000_0000, 4'hf, q);
  endtask

  // Pulses one core event for a cycle and checks the phase it leads to.
  task automatic ev_go(input int k, input logic [3:0] exp);
    @(posedge clk_i);
    ev <= 7'h01 << k;
    @(posedge clk_i);
    ev <= 7'h00;
    #1;
    cmp32({28'h0, exp}, {28'h0, phase});
  endtask

  function automatic logic [23:0] crc_step(input logic [23:0] c, input logic [23:0] p, input logic b);
    crc_step = {c[22:0], 1'b0} ^ ((b ^ c[23]) ? (p | 24'h000001) : 24'h000000);
  endfunction

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // Reset values of every named register, the first and last segment, and an unmapped place.
  task automatic t_reset();
    logic [11:0] al[10];
    logic [31:0] q;
    al = '{12'h538, 12'h53c, 12'h544, 12'h548, 12'h550, 12'h554, 12'h560, 12'h600, 12'h61c, 12'h700};
    foreach (al[i]) begin
      rreg(al[i], q);
      cmp32(32'h0000_0000, (al[i] == rcs_pkg::OFS_CRC_POLY) ? (q & 32'hffff_fffe) : q);
    end
  endtask

  // Write and read back, byte lanes, read-only and unmapped writes.
  task automatic t_regs();
    logic [31:0] q;
    wreg(rcs_pkg::OFS_CRC_POLY, 32'h0000_065a);
    rreg(rcs_pkg::OFS_CRC_POLY, q);
    cmp32(32'h0000_065a, q & 32'hffff_fffe);
    for (int n = 0; n < 8; n++) wreg(12'h600 + 12'(n * 4), 32'h0a0b_0c00 | 32'(n));
    for (int n = 0; n < 8; n++) begin
      rreg(12'h600 + 12'(n * 4), q);
      cmp32(32'h0a0b_0c00 | 32'(n), q);
      cmp32(32'h0a0b_0c00 | 32'(n), seg[32 * n +: 32]);
    end
    bus(1'b1, 12'h60c, 32'haabb_ccdd, 4'h2, q);
    #1;
    cmp32(32'h0a0b_cc03, seg[127:96]);
    wreg(rcs_pkg::OFS_PHASE, 32'h0000_000b);
    wreg(12'h700, 32'hffff_ffff);
    rreg(rcs_pkg::OFS_PHASE, q);
    cmp32(32'h0000_0000, q);
    rreg(12'h700, q);
    cmp32(32'h0000_0000, q);
  endtask

  // Receive walk: CRC seed at each frame start, whitening seed at the first, one bit, match and gap restart.
  task automatic t_rx();
    logic [31:0] q;
    logic        m;
    int          n;
    wreg(rcs_pkg::OFS_CRC_SEED, 32'h00a5_5a3c);
    wreg(rcs_pkg::OFS_WHITEN_SEED, 32'h0000_0045);
    wreg(rcs_pkg::OFS_BIT_MATCH, 32'h0000_0001);
    wreg(rcs_pkg::OFS_IFS_GAP, 32'h0000_0001);
    @(posedge clk_i);
    rv   <= 1'b1;
    rssi <= 7'h5a;
    @(posedge clk_i);
    rv <= 1'b0;
    rreg(rcs_pkg::OFS_RSSI, q);
    cmp32(32'h0000_005a, q);
    ev_go(0, rcs_pkg::PH_RX_RAMPUP);
    ev_go(2, rcs_pkg::PH_RX_WAITING);
    ev_go(3, rcs_pkg::PH_RX_ACTIVE);
    cmp32(32'h00a5_5a3c, {8'h0, crc});
    cmp32(32'h0000_0001, {31'h0, wbit});
    @(posedge clk_i);
    tick <= 1'b1;
    dbit <= 1'b0;
    @(posedge clk_i);
    tick <= 1'b0;
    #1;
    cmp32({8'h0, crc_step(24'ha55a3c, 24'h00065a, 1'b0)}, {8'h0, crc});
    m = match;
    @(posedge clk_i);
    #1;
    m = m | match;
    cmp32(32'h0000_0001, {31'h0, m});
    rreg(rcs_pkg::OFS_PHASE, q);
    cmp32(32'h0000_0003, q);
    ev_go(4, rcs_pkg::PH_RX_WAITING);
    n = 1;
    while (gap_done !== 1'b1 && n < 300) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    cmp32(32'h0000_0001, {31'h0, (n >= 99 && n <= 101)});
    @(posedge clk_i);
    #1;
    cmp32({28'h0, rcs_pkg::PH_RX_ACTIVE}, {28'h0, phase});
    cmp32(32'h00a5_5a3c, {8'h0, crc});
    ev_go(5, rcs_pkg::PH_RX_SHUTDOWN);
    ev_go(6, rcs_pkg::PH_DISABLED);
  endtask

  // Transmit walk through every transmit code.
  task automatic t_tx();
    ev_go(1, rcs_pkg::PH_TX_RAMPUP);
    ev_go(2, rcs_pkg::PH_TX_WAITING);
    ev_go(3, rcs_pkg::PH_TX_ACTIVE);
    ev_go(4, rcs_pkg::PH_TX_WAITING);
    ev_go(5, rcs_pkg::PH_TX_SHUTDOWN);
    ev_go(6, rcs_pkg::PH_DISABLED);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_regs();
    t_rx();
    t_tx();
    complete_run();
  end
endmodule
